// File: logic/mlf_apb_master.sv
/*
  APB master toward the device: one transfer per request; a req held past done repeats it.
  Assumes the requester holds req and its fields stable until done.
*/
`timescale 1ns/1ps
`default_nettype none
module mlf_apb_master (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        req,
  input  wire logic        req_wr,
  input  wire logic [31:0] req_addr,
  input  wire logic [31:0] req_wdata,
  output logic             done,
  output logic      [31:0] rdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  typedef enum logic [1:0] {M_IDLE, M_SETUP, M_ACC, M_DONE} mlf_mst_t;
  mlf_mst_t    st_r, st_nxt;
  logic [31:0] rdata_nxt;

  // ========================================================================
  // Phase sequencing; a req still held after the done cycle starts another transfer from idle
  always_comb begin
    st_nxt    = st_r;
    rdata_nxt = rdata;
    case (st_r)
      M_IDLE:  if (req) st_nxt = M_SETUP;
      M_SETUP: st_nxt = M_ACC;
      M_ACC: if (pready) begin
        st_nxt    = M_DONE;
        rdata_nxt = prdata;
      end
      M_DONE:  st_nxt = M_IDLE;
      default: st_nxt = M_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r  <= M_IDLE;
      rdata <= 32'h0000_0000;
    end else begin
      st_r  <= st_nxt;
      rdata <= rdata_nxt;
    end
  end

  // Bus pins from state; fields mirror the held request
  always_comb begin
    psel    = (st_r == M_SETUP) || (st_r == M_ACC);
    penable = (st_r == M_ACC);
    done    = (st_r == M_DONE);
  end

  // Address and data registered, stable through the access phase
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pwrite <= 1'b0;
      paddr  <= 32'h0000_0000;
      pwdata <= 32'h0000_0000;
    end else if (st_r == M_IDLE && req) begin
      pwrite <= req_wr;
      paddr  <= req_addr;
      pwdata <= req_wdata;
    end
  end
endmodule : mlf_apb_master
`default_nettype wire

// File: logic/mlf_decode.sv
/*
  Unpacks the two latency words, marks valid levels and applies the
  zero-level and dense-module corrections. Purely combinational.
  Assumes its inputs come from registers in the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mlf_params.svh"
module mlf_decode (
  input  wire logic [31:0] word_lo,
  input  wire logic [31:0] word_hi,
  input  wire logic [31:0] mc0,
  input  wire logic [31:0] mc1,
  output logic      [63:0] lat,
  output logic       [7:0] valid,
  output logic             dense
);
  logic [63:0] raw;
  logic [63:0] mods;
  logic  [3:0] hit;
  logic        l0_zero;

  // byte order, level i in byte i
  assign raw     = {word_hi, word_lo};
  assign mods    = {mc1, mc0};
  assign l0_zero = (raw[7:0] == 8'h00);
  assign dense   = |hit;

  // ========================================================================
  // Per level validity and correction; equal neighbours pass untouched
  for (genvar i = 0; i < 8; i++) begin : g_lvl
    logic [7:0] v;
    always_comb begin
      // zero level 0 lifts valid levels
      v = raw[8*i +: 8] + (l0_zero ? `MLF_ZERO_ADD_US : 8'h00);
      if (i == 0 && dense) v = v + `MLF_DENSE_ADD_US;
    end
    if (i == 0) begin : g_l0
      assign valid[0] = 1'b1;
    end else begin : g_ln
      // zero level kills itself and above; repeats allowed
      assign valid[i] = valid[i-1] && (raw[8*i +: 8] != 8'h00);
    end
    assign lat[8*i +: 8] = valid[i] ? v : 8'h00;
  end

  // ========================================================================
  // Dense module detection, two modules per channel
  for (genvar m = 0; m < 4; m++) begin : g_mod
    logic [15:0] f;
    logic  [7:0] sz;
    logic        x16;
    logic        dual;
    assign f    = mods[`MLF_MOD_STRIDE*m +: `MLF_MOD_STRIDE];
    assign sz   = f[7:0];
    assign x16  = f[`MLF_MOD_X16_BIT];
    assign dual = f[`MLF_MOD_DUAL_BIT];
    assign hit[m] = (sz != 8'h00) &&
                    ((!x16 && !dual && sz == `MLF_SZ_16G) ||
                     (!x16 &&  dual && sz == `MLF_SZ_32G) ||
                     ( x16 && !dual && sz == `MLF_SZ_8G)  ||
                     ( x16 &&  dual && sz == `MLF_SZ_16G));
  end
endmodule : mlf_decode
`default_nettype wire

// File: logic/mlf_params.svh
/*
  Constants of the memory latency fetch controller: software register map,
  device-side addresses, field layouts and timing counts.
  Assumes a 200 MHz ref_clk and a device reached by one APB master port.
*/
//
// Notes on behaviour
// - Check that the previous mailbox transaction finished before a new request.
// - First request writes low mailbox word zero and high mailbox word zero.
// - Launch writes interface word: run/busy set, address control zero, command 06h.
// - Done when run/busy reads 0 and completion code reads 00h; poll until then.
// - No completion within 100 us: abandon, keep display planes disabled.
// - After the first success, read low mailbox word for levels 0 to 3.
// - Repeat with low word one, high word zero, for levels 4 to 7.
// - Level from 1 upward reading zero invalidates it and all higher levels.
// - Equal values in neighbouring levels are legal, never an error.
// - Level 0 reading zero adds two microseconds to every valid level.
// - Module configuration read for both channels at memctl base plus 500Ch, 5010h.
// - Populated module matching one of four rank/width/size combinations is dense.
// - Any dense module raises level 0 by one microsecond.
// - Disable scaling if interlaced or a plane cannot tolerate 10 us, else enable.
// - Disable masks all but best point; enable unmasks all adequate points.
// - Simple policy: disable when several pipes or interlace, else enable.
`ifndef MLF_PARAMS_SVH
`define MLF_PARAMS_SVH

// ==========================================================================
// Software register offsets
`define MLF_SW_CTRL        12'h000
`define MLF_SW_CFG         12'h004
`define MLF_SW_POINTS      12'h008
`define MLF_SW_STATUS      12'h00C
`define MLF_SW_LAT_LO      12'h010
`define MLF_SW_LAT_HI      12'h014
`define MLF_SW_VALID       12'h018
`define MLF_CFG_RST        32'h0000_0000
`define MLF_POINTS_RST     32'h0000_0000

// ==========================================================================
// Device addresses
`define MLF_MB_IF_ADDR     32'h0000_0000
`define MLF_MB_LO_ADDR     32'h0000_0004
`define MLF_MB_HI_ADDR     32'h0000_0008
`define MLF_PT_MASK_ADDR   32'h0000_000C
`define MLF_MEMCTL_BASE    32'h0001_0000
`define MLF_MODCFG0_OFS    32'h0000_500C
`define MLF_MODCFG1_OFS    32'h0000_5010

// ==========================================================================
// Mailbox interface word
`define MLF_MB_RUN_BIT     31
`define MLF_MB_CODE_MSB    7
`define MLF_MB_CMD_LAT     8'h06
`define MLF_MB_OK          8'h00
`define MLF_LAUNCH_WORD    32'h8000_0006
`define MLF_SET0_WORD      32'h0000_0000
`define MLF_SET1_WORD      32'h0000_0001

// ==========================================================================
// Module configuration fields, 16 bits per module, two per channel
`define MLF_MOD_STRIDE     16
`define MLF_MOD_X16_BIT    8
`define MLF_MOD_DUAL_BIT   9
`define MLF_SZ_8G          8'h08
`define MLF_SZ_16G         8'h10
`define MLF_SZ_32G         8'h20
`define MLF_ZERO_ADD_US    8'h02
`define MLF_DENSE_ADD_US   8'h01

// ==========================================================================
// Timing
`define MLF_CLK_MHZ        200
`define MLF_TIMEOUT_US     100
`define MLF_BLOCK_TIME_US  8'h0A

`endif

// File: logic/mlf_pkg.sv
/*
  Types of the memory latency fetch controller.
  Assumes mlf_params.svh supplies all numeric constants.
*/
package mlf_pkg;
  // ========================================================================
  // Sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_CHK, S_WLO, S_WHI, S_WIF, S_POLL, S_RDLO, S_MC0, S_MC1, S_MASK
  } mlf_state_t;
endpackage : mlf_pkg

// File: logic/mlf_top.sv
/*
  Memory latency fetch controller: software APB slave, mailbox sequencer
  and scaling policy, driving the device through an APB master.
  Assumes the device answers on the same ref_clk; no synchronisers needed.
*/
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "mlf_params.svh"
module mlf_top
  import mlf_pkg::*;
#(
  parameter int TIMEOUT_CYC = `MLF_TIMEOUT_US * `MLF_CLK_MHZ
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        s_psel,
  input  wire logic        s_penable,
  input  wire logic        s_pwrite,
  input  wire logic [11:0] s_paddr,
  input  wire logic [31:0] s_pwdata,
  output logic      [31:0] s_prdata,
  output logic             s_pready,
  output logic             s_pslverr,
  output logic             m_psel,
  output logic             m_penable,
  output logic             m_pwrite,
  output logic      [31:0] m_paddr,
  output logic      [31:0] m_pwdata,
  input  wire logic [31:0] m_prdata,
  input  wire logic        m_pready,
  output logic             planes_ok,
  output logic             dvfs_disable
);
  mlf_state_t  state_r, state_nxt;
  logic        set_r, set_nxt;
  logic        done_r, done_nxt;
  logic        fail_r, fail_nxt;
  logic        dvfs_r, dvfs_nxt;
  logic [15:0] tmr_r, tmr_nxt;
  logic [31:0] lo_r, lo_nxt, hi_r, hi_nxt;
  logic [31:0] mc0_r, mc0_nxt, mc1_r, mc1_nxt;
  logic [31:0] cfg_r, cfg_nxt, pts_r, pts_nxt;
  logic [31:0] prd_nxt;
  logic        sw_wr, sw_setup, start, apply, mapped;
  logic        req, req_wr, mst_done;
  logic [31:0] req_addr, req_wdata, mst_rdata;
  logic [63:0] lat;
  logic  [7:0] valid;
  logic        dense, dis_want, rb, code_ok, expired;

  // ========================================================================
  // Helpers
  mlf_apb_master u_mst (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .req       (req),
    .req_wr    (req_wr),
    .req_addr  (req_addr),
    .req_wdata (req_wdata),
    .done      (mst_done),
    .rdata     (mst_rdata),
    .psel      (m_psel),
    .penable   (m_penable),
    .pwrite    (m_pwrite),
    .paddr     (m_paddr),
    .pwdata    (m_pwdata),
    .prdata    (m_prdata),
    .pready    (m_pready)
  );

  mlf_decode u_dec (
    .word_lo (lo_r),
    .word_hi (hi_r),
    .mc0     (mc0_r),
    .mc1     (mc1_r),
    .lat     (lat),
    .valid   (valid),
    .dense   (dense)
  );

  // ========================================================================
  // Software slave decode; zero wait states
  always_comb begin
    sw_setup  = s_psel && !s_penable;
    sw_wr     = s_psel && s_penable && s_pwrite;
    s_pready  = s_psel && s_penable;
    mapped    = (s_paddr <= `MLF_SW_VALID) && (s_paddr[1:0] == 2'b00);
    s_pslverr = s_pready && !mapped;
    start     = sw_wr && s_paddr == `MLF_SW_CTRL && s_pwdata[0];
    apply     = sw_wr && s_paddr == `MLF_SW_CTRL && s_pwdata[1];
  end

  // Read data latched in the setup cycle, so it comes from a flip-flop
  always_comb begin
    prd_nxt = s_prdata;
    if (sw_setup) begin
      case (s_paddr)
        `MLF_SW_CFG:    prd_nxt = cfg_r;
        `MLF_SW_POINTS: prd_nxt = pts_r;
        `MLF_SW_STATUS: prd_nxt = {27'h0, dvfs_r, dense, fail_r, done_r,
                                   state_r != S_IDLE};
        `MLF_SW_LAT_LO: prd_nxt = lat[31:0];
        `MLF_SW_LAT_HI: prd_nxt = lat[63:32];
        `MLF_SW_VALID:  prd_nxt = {24'h0, valid};
        default:        prd_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ========================================================================
  // Scaling policy
  always_comb begin
    // simple policy: several pipes or interlace
    if (cfg_r[1])
      dis_want = cfg_r[0] || (cfg_r[7:4] > 4'h1);
    // interlace or a plane short of the block time
    else
      dis_want = cfg_r[0] || (cfg_r[15:8] < `MLF_BLOCK_TIME_US);
  end

  // ========================================================================
  // Device request fields per state
  always_comb begin
    req       = 1'b1;
    req_wr    = 1'b0;
    req_addr  = `MLF_MB_IF_ADDR;
    req_wdata = 32'h0000_0000;
    case (state_r)
      S_CHK, S_POLL: req_addr = `MLF_MB_IF_ADDR;
      S_WLO: begin
        req_wr    = 1'b1;
        req_addr  = `MLF_MB_LO_ADDR;
        req_wdata = set_r ? `MLF_SET1_WORD : `MLF_SET0_WORD;
      end
      S_WHI: begin
        req_wr    = 1'b1;
        req_addr  = `MLF_MB_HI_ADDR;
        req_wdata = 32'h0000_0000;
      end
      S_WIF: begin
        req_wr    = 1'b1;
        req_wdata = `MLF_LAUNCH_WORD;
      end
      S_RDLO: req_addr = `MLF_MB_LO_ADDR;
      S_MC0:  req_addr = `MLF_MEMCTL_BASE + `MLF_MODCFG0_OFS;
      S_MC1:  req_addr = `MLF_MEMCTL_BASE + `MLF_MODCFG1_OFS;
      S_MASK: begin
        req_wr    = 1'b1;
        req_addr  = `MLF_PT_MASK_ADDR;
        // keep only best point, or all adequate ones
        req_wdata = {24'h0, dvfs_r ? ~pts_r[7:0] : ~pts_r[15:8]};
      end
      default: req = 1'b0;
    endcase
  end

  // ========================================================================
  // Sequencer; the timer only runs while waiting on the mailbox
  always_comb begin
    rb        = mst_rdata[`MLF_MB_RUN_BIT];
    code_ok   = mst_rdata[`MLF_MB_CODE_MSB:0] == `MLF_MB_OK;
    expired   = tmr_r >= 16'(TIMEOUT_CYC);
    state_nxt = state_r;
    set_nxt   = set_r;
    done_nxt  = done_r;
    fail_nxt  = fail_r;
    dvfs_nxt  = dvfs_r;
    lo_nxt    = lo_r;
    hi_nxt    = hi_r;
    mc0_nxt   = mc0_r;
    mc1_nxt   = mc1_r;
    tmr_nxt   = (state_r == S_CHK || state_r == S_POLL) ? tmr_r + 16'h0001
                                                        : 16'h0000;
    case (state_r)
      S_IDLE: if (start) begin
        state_nxt = S_CHK;
        set_nxt   = 1'b0;
        done_nxt  = 1'b0;
        fail_nxt  = 1'b0;
      end else if (apply) begin
        state_nxt = S_MASK;
        dvfs_nxt  = dis_want;
      end
      S_CHK: if (mst_done) begin
        if (!rb) state_nxt = S_WLO;
        else if (expired) begin
          state_nxt = S_IDLE;
          fail_nxt  = 1'b1;
        end
      end
      S_WLO: if (mst_done) state_nxt = S_WHI;
      S_WHI: if (mst_done) state_nxt = S_WIF;
      S_WIF: if (mst_done) state_nxt = S_POLL;
      S_POLL: if (mst_done) begin
        // success needs run/busy clear and code 00h
        if (!rb && code_ok) state_nxt = S_RDLO;
        else if (!rb) begin
          state_nxt = S_IDLE;
          fail_nxt  = 1'b1;
        end
        else if (expired) begin
          state_nxt = S_IDLE;
          fail_nxt  = 1'b1;
        end
      end
      S_RDLO: if (mst_done) begin
        if (!set_r) begin
          lo_nxt    = mst_rdata;
          set_nxt   = 1'b1;
          state_nxt = S_CHK;
        end else begin
          hi_nxt    = mst_rdata;
          state_nxt = S_MC0;
        end
      end
      S_MC0: if (mst_done) begin
        mc0_nxt   = mst_rdata;
        state_nxt = S_MC1;
      end
      S_MC1: if (mst_done) begin
        mc1_nxt   = mst_rdata;
        done_nxt  = 1'b1;
        state_nxt = S_IDLE;
      end
      S_MASK: if (mst_done) state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  // Register stage for sequencer and software registers
  always_comb begin
    cfg_nxt = (sw_wr && s_paddr == `MLF_SW_CFG) ? s_pwdata : cfg_r;
    pts_nxt = (sw_wr && s_paddr == `MLF_SW_POINTS) ? s_pwdata : pts_r;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r  <= S_IDLE;
      set_r    <= 1'b0;
      done_r   <= 1'b0;
      fail_r   <= 1'b0;
      dvfs_r   <= 1'b0;
      tmr_r    <= 16'h0000;
      lo_r     <= 32'h0000_0000;
      hi_r     <= 32'h0000_0000;
      mc0_r    <= 32'h0000_0000;
      mc1_r    <= 32'h0000_0000;
      cfg_r    <= `MLF_CFG_RST;
      pts_r    <= `MLF_POINTS_RST;
      s_prdata <= 32'h0000_0000;
    end else begin
      state_r  <= state_nxt;
      set_r    <= set_nxt;
      done_r   <= done_nxt;
      fail_r   <= fail_nxt;
      dvfs_r   <= dvfs_nxt;
      tmr_r    <= tmr_nxt;
      lo_r     <= lo_nxt;
      hi_r     <= hi_nxt;
      mc0_r    <= mc0_nxt;
      mc1_r    <= mc1_nxt;
      cfg_r    <= cfg_nxt;
      pts_r    <= pts_nxt;
      s_prdata <= prd_nxt;
    end
  end

  // planes held off until a clean fetch
  assign planes_ok    = done_r && !fail_r;
  assign dvfs_disable = dvfs_r;

  // ========================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_launch;
    state_r == S_WIF && m_psel |-> m_pwrite && m_pwdata == 32'h8000_0006;
  endproperty
  a_launch: assert property (p_launch) else $error("bad launch word");

  property p_set0;
    state_r == S_WLO && !set_r && m_penable |-> m_pwdata == 32'h0 && m_paddr == 32'h4;
  endproperty
  a_set0: assert property (p_set0) else $error("bad first select");

  property p_set1;
    state_r == S_WLO && set_r && m_penable |-> m_pwdata == 32'h1;
  endproperty
  a_set1: assert property (p_set1) else $error("bad second select");

  property p_chk;
    $rose(state_r == S_WLO) |-> $past(state_r) == S_CHK && $past(mst_done) && !$past(rb);
  endproperty
  a_chk: assert property (p_chk) else $error("launch without idle mailbox");

  property p_ok;
    state_r == S_POLL && mst_done && !rb && code_ok |=> state_r == S_RDLO ##1 !fail_r;
  endproperty
  a_ok: assert property (p_ok) else $error("success not taken");

  property p_err;
    state_r == S_POLL && mst_done && !rb && !code_ok |=> fail_r && state_r == S_IDLE;
  endproperty
  a_err: assert property (p_err) else $error("error code not failed");

  property p_tmo;
    state_r == S_POLL && mst_done && rb && expired |=> fail_r && !planes_ok;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout not failed");

  property p_order;
    state_r == S_RDLO && mst_done && !set_r |=> set_r && state_r == S_CHK
      && lo_r == $past(mst_rdata);
  endproperty
  a_order: assert property (p_order) else $error("second request out of order");

  property p_mask;
    state_r == S_MASK && m_psel |-> m_pwdata[7:0] == (dvfs_r ? ~pts_r[7:0] : ~pts_r[15:8]);
  endproperty
  a_mask: assert property (p_mask) else $error("bad point mask");

  property p_zero;
    lo_r[7:0] == 8'h00 && lo_r[15:8] != 8'h00 |-> lat[15:8] == lo_r[15:8] + 8'h02;
  endproperty
  a_zero: assert property (p_zero) else $error("zero level not lifted");

  property p_inval;
    lo_r[15:8] == 8'h00 |-> valid[7:1] == 7'h00 && lat[63:8] == 56'h0;
  endproperty
  a_inval: assert property (p_inval) else $error("invalid level kept");
endmodule : mlf_top
`default_nettype wire

// File: testbench/mlf_dev_model.sv
/* Device model: latency mailbox, module config words, point mask.
   Assumes the bench sets answer fields between clock edges. */
`timescale 1ns/1ps
`default_nettype none
`include "mlf_params.svh"
module mlf_dev_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready
);
  // ==========================================================================
  // State; answer fields are set by the bench
  logic [31:0] w0, w1, mc0, mc1, dly, cnt, lo, hi, mask, last, rd;
  logic [7:0]  code;
  logic        slow, seq_err, tick;
  int          nl;

  always @* begin
    case (paddr)
      `MLF_MB_IF_ADDR:                     rd = {cnt != 0, 23'h0, (cnt != 0) ? 8'h06 : code};
      `MLF_MB_LO_ADDR:                     rd = lo;
      `MLF_MB_HI_ADDR:                     rd = hi;
      `MLF_PT_MASK_ADDR:                   rd = mask;
      `MLF_MEMCTL_BASE + `MLF_MODCFG0_OFS: rd = mc0;
      `MLF_MEMCTL_BASE + `MLF_MODCFG1_OFS: rd = mc1;
      default:                             rd = 32'h0;
    endcase
  end

  // Released bus does not keep the last word
  assign prdata = psel ? rd : ~last;
  assign pready = psel & penable & (~slow | tick);

  // answer replaces low word; mask opens all points at reset
  always @(posedge ref_clk) begin
    tick <= ~tick;
    if (!rst_n) begin
      {lo, hi, mask, last, cnt, seq_err, tick} <= '0;
    end else begin
      if (cnt != 0) cnt <= cnt - 1;
      if (cnt == 1) lo <= lo[0] ? w1 : w0;
      if (pready) begin
        last <= rd;
        if (cnt != 0 && (pwrite || paddr != `MLF_MB_IF_ADDR)) seq_err <= 1'b1;
        if (pwrite) begin
          case (paddr)
            `MLF_MB_LO_ADDR:   lo <= pwdata;
            `MLF_MB_HI_ADDR:   hi <= pwdata;
            `MLF_PT_MASK_ADDR: mask <= pwdata;
            `MLF_MB_IF_ADDR: begin
              cnt <= dly + 1;
              nl  <= nl + 1;
              if (pwdata !== 32'h8000_0006 || hi !== 32'h0 || lo !== {31'h0, nl[0]})
                seq_err <= 1'b1;
            end
            default: ;
          endcase
        end
      end
    end
  end
endmodule : mlf_dev_model
`default_nettype wire

// File: testbench/tb_top.sv
/* Self-checking bench of mlf_top: random latency words and module layouts.
   Assumes mlf_dev_model on the device port. */
`timescale 1ns/1ps
`default_nettype none
`include "mlf_params.svh"
module tb_top;
  // ==========================================================================
  // Signals
  logic        ref_clk = 1'b0, rst_n = 1'b0, s_psel = 1'b0, s_penable = 1'b0;
  logic        s_pwrite = 1'b0, s_pready, s_pslverr, m_psel, m_penable, m_pwrite;
  logic        m_pready, planes_ok, dvfs_disable, err, ok, dis;
  logic [11:0] s_paddr = 12'h000;
  logic [31:0] s_pwdata = 32'h0, s_prdata, m_paddr, m_pwdata, m_prdata, rd, cfg, a, b;
  logic [31:0] seed = 32'h376664D2;
  logic [63:0] raw;
  int          errors = 0, samples_checked = 0, cyc = 0;

  // Clock of 5 ns
  always #2.5 ref_clk = ~ref_clk;

  mlf_top #(.TIMEOUT_CYC(50)) i_mlf_top (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_psel(s_psel), .s_penable(s_penable),
    .s_pwrite(s_pwrite), .s_paddr(s_paddr), .s_pwdata(s_pwdata), .s_prdata(s_prdata),
    .s_pready(s_pready), .s_pslverr(s_pslverr), .m_psel(m_psel), .m_penable(m_penable),
    .m_pwrite(m_pwrite), .m_paddr(m_paddr), .m_pwdata(m_pwdata), .m_prdata(m_prdata),
    .m_pready(m_pready), .planes_ok(planes_ok), .dvfs_disable(dvfs_disable));
  mlf_dev_model i_mlf_dev_model (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(m_psel), .penable(m_penable),
    .pwrite(m_pwrite), .paddr(m_paddr), .pwdata(m_pwdata), .prdata(m_prdata),
    .pready(m_pready));

  // ==========================================================================
  // Expectations
  function logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  // Module field: size 0, 4, 8, 16 or 32 GB, random rank and width
  function logic [15:0] modf(input logic [31:0] r);
    return {6'h00, r[1:0], r[4] ? 8'h00 : (8'h04 << r[3:2])};
  endfunction : modf

  function logic dense(input logic [31:0] x, input logic [31:0] y);
    logic [63:0] m;
    m = {y, x};
    dense = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if ({m[16*i+8 +: 2], m[16*i +: 8]} inside {10'h010, 10'h220, 10'h108, 10'h310})
        dense = 1'b1;
    end
  endfunction : dense

  // Valid mask over corrected levels; invalid levels read zero
  function logic [71:0] exp_lat(input logic [63:0] r, input logic dn);
    logic [63:0] l;
    logic [7:0]  v;
    logic        good;
    good = 1'b1;
    for (int k = 0; k < 8; k++) begin
      if (k > 0 && r[8*k +: 8] == 8'h00) good = 1'b0;
      v[k] = good;
      l[8*k +: 8] = good ? r[8*k +: 8] + ((r[7:0] == 8'h00) ? 8'h02 : 8'h00) : 8'h00;
    end
    if (dn) l[7:0] = l[7:0] + 8'h01;
    return {v, l};
  endfunction : exp_lat

  // ==========================================================================
  // Bus and check tasks
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // Request held until pready is seen at an edge
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge ref_clk);
    s_psel   <= 1'b1;
    s_pwrite <= w;
    s_paddr  <= ad;
    s_pwdata <= d;
    @(posedge ref_clk);
    s_penable <= 1'b1;
    do @(posedge ref_clk); while (s_pready !== 1'b1);
    rd = s_prdata;
    err = s_pslverr;
    s_psel    <= 1'b0;
    s_penable <= 1'b0;
  endtask : apb

  task wait_idle();
    do apb(1'b0, `MLF_SW_STATUS, 32'h0); while (rd[0] !== 1'b0);
  endtask : wait_idle

  task fetch(input logic [31:0] dl, input logic [7:0] cd, input int pre);
    logic [71:0] x;
    @(negedge ref_clk);
    i_mlf_dev_model.w0   = raw[31:0];
    i_mlf_dev_model.w1   = raw[63:32];
    i_mlf_dev_model.mc0  = a;
    i_mlf_dev_model.mc1  = b;
    i_mlf_dev_model.dly  = dl;
    i_mlf_dev_model.code = cd;
    i_mlf_dev_model.nl   = 0;
    i_mlf_dev_model.slow = seed[0];
    i_mlf_dev_model.cnt  = pre;
    x = exp_lat(raw, dense(a, b));
    ok = (cd == 8'h00) && (dl < 32'd40);
    apb(1'b1, `MLF_SW_CTRL, 32'h1);
    wait_idle();
    apb(1'b0, `MLF_SW_STATUS, 32'h0);
    if (ok) chk(rd[3:0], {dense(a, b), 3'b010});
    else chk(rd[2:0], 3'b100);
    chk(planes_ok, ok);
    if (ok) begin
      apb(1'b0, `MLF_SW_LAT_LO, 32'h0);
      chk(rd, x[31:0]);
      apb(1'b0, `MLF_SW_LAT_HI, 32'h0);
      chk(rd, x[63:32]);
      apb(1'b0, `MLF_SW_VALID, 32'h0);
      chk(rd, {24'h0, x[71:64]});
    end
    chk(i_mlf_dev_model.seq_err, 1'b0);
  endtask : fetch

  task report_and_stop();
    $display("Checks made %0d, errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // Hang guard, far above the expected run length
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {i_mlf_dev_model.slow, i_mlf_dev_model.cnt, i_mlf_dev_model.code} = '0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk({planes_ok, dvfs_disable}, 2'b00);
    // Reset values; the last address is unmapped
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk(rd, (i == 4) ? {24'h0, `MLF_ZERO_ADD_US} : {31'h0, i == 6});
      chk(err, i == 7);
    end
    raw = 64'h0;
    a = 32'h0;
    b = 32'h0;
    fetch(32'd3, 8'h01, 0);
    fetch(32'h0FFF_FFFF, 8'h00, 0);
    // Random words with forced zeros, equal levels and a busy mailbox
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      raw[31:0] = seed;
      seed = xs(seed);
      raw[63:32] = seed;
      if (seed[4:2] == 3'd0) raw[8*seed[7:5] +: 8] = 8'h00;
      if (i == 0) raw = 64'h0505_0505_0505_0500;
      if (i == 1) raw = 64'h1211_100F_000C_0B0A;
      a = {modf(xs(seed)), modf(seed)};
      seed = xs(seed);
      b = {modf(xs(seed)), modf(seed)};
      fetch({27'h0, seed[12:8]}, 8'h00, (i == 2) ? 30 : 0);
    end
    // Scaling policy, tolerance around the block time
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      cfg = {16'h0, 8'h08 + {6'h0, seed[9:8]}, seed[7:4], 2'b00, seed[1:0]};
      dis = seed[1] ? (seed[7:4] > 4'h1 || seed[0]) : (seed[0] || seed[9:8] < 2'd2);
      apb(1'b1, `MLF_SW_CFG, cfg);
      apb(1'b1, `MLF_SW_POINTS, {16'h0, seed[31:16]});
      apb(1'b0, `MLF_SW_CFG, 32'h0);
      chk(rd, cfg);
      apb(1'b1, `MLF_SW_CTRL, 32'h2);
      wait_idle();
      chk(dvfs_disable, dis);
      chk(rd[4], dis);
      chk(i_mlf_dev_model.mask, {24'h0, dis ? ~seed[23:16] : ~seed[31:24]});
    end
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
